// [hw/tbsc_pkg.sv]
// Purpose: shared constants and types for the bias controller control logic
// Assumes: system clock 125 MHz, serial clock on its own domain
// Notes: frame field layout follows the 30/32-bit write frame
package tbsc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned STARTUP_TYP_US = 180;
  localparam int unsigned STARTUP_MAX_US = 300;
  // startup finishes at the typical time, well inside the limit
  localparam int unsigned STARTUP_CYC = STARTUP_TYP_US * CLK_MHZ;
  localparam int unsigned BOOST_AVG_KHZ = 2000;
  localparam int unsigned BOOST_MIN_KHZ = 800;
  localparam int unsigned BOOST_MAX_KHZ = 3200;
  // half periods in system cycles, shortest at the top frequency
  localparam int unsigned BOOST_HALF_MIN = (CLK_MHZ * 1000) / (2 * BOOST_MAX_KHZ);
  localparam int unsigned BOOST_HALF_MAX = (CLK_MHZ * 1000) / (2 * BOOST_MIN_KHZ);
  localparam int unsigned BOOST_HALF_AVG = (CLK_MHZ * 1000) / (2 * BOOST_AVG_KHZ);
  localparam int unsigned FRAME_SHORT = 30;
  localparam int unsigned FRAME_LONG = 32;
  localparam logic [3:0] BOOST_LEVEL_RST = 4'hf;
  localparam logic [1:0] HDR_LONG = 2'h3;
  localparam logic [7:0] DEV_ID = 8'ha4;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0] ADDR_BOOST = 5'h1f;
  localparam logic [4:0] ADDR_PWR = 5'h1e;
  localparam logic [1:0] PWR_ACTIVE = 2'h0;
  localparam logic [1:0] PWR_STARTUP = 2'h1;
  localparam logic [1:0] PWR_LOWPWR = 2'h2;
  localparam int unsigned FRM_CNT_W = 6;
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] data;
  } tbsc_cmd_t;
  typedef enum logic [1:0] {TBSC_SHUTDOWN, TBSC_STARTUP, TBSC_ACTIVE, TBSC_LOWPWR} tbsc_mode_t;
endpackage

// [hw/tbsc_top.sv]
// Purpose: power sequencing, boost control and 3-wire write receiver
// Assumes: io_supply_ok_i is a digital level from the supply detector
// Notes: serial front end runs on the serial clock, words cross on synced cs fall
// Operation
// - no io supply: everything held in shutdown
// - io supply up: start with defaults, go active
// - shutdown to active within 300 us
// - boost clock spread 0.8 to 3.2 MHz
// - in startup and active: boost on below reference, off above
// - shutdown puts bias outputs high impedance
// - per-frame protocol recognition without configuration
// - write-only slave, no read-back
// - frame length decided per frame
// - chip select change mid-frame discards bits
// - msb first, sample on rising clock
// - commit command on chip select fall
// - only edge counts of 30 or 32 modulo 64 accepted, edge count wraps at 64
// - io power-on reset clears registers, not the serial link flops
// - boost level defaults to maximum code
// - io supply low forces shutdown, loses state
`timescale 1ns/1ps
`default_nettype none
module tbsc_top #(
  parameter int unsigned STARTUP_CYCLES = tbsc_pkg::STARTUP_CYC
) (
  input wire logic mclk_i,                 // system clock 125 MHz
  input wire logic rst_i,                  // sync reset, active high
  input wire logic analog_supply_ok_i,     // analog supply present
  input wire logic io_supply_ok_i,         // io supply present, async level
  input wire logic sclk_i,                 // serial clock, link domain
  input wire logic cs_i,                   // chip select, high during frame
  input wire logic data_i,                 // serial data in
  input wire logic boost_below_ref_i,      // comparator: boosted_voltage below ref
  output logic data_o,                     // data pin drive value
  output logic data_oe_o,                  // data pin enable, never set in 3-wire
  output logic boost_sw_o,                 // boost switch gate
  output logic [3:0] boost_level_o,        // boost reference level code
  output logic outputs_hiz_o,              // bias outputs high impedance
  output logic active_o,                   // device in active mode
  output logic cmd_valid_o,                // one-cycle pulse: command taken
  output tbsc_pkg::tbsc_cmd_t cmd_o        // last command taken
);
  import tbsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift and count while cs high
  logic [31:0] sh_ff;
  logic [FRM_CNT_W-1:0] cnt_ff;
  logic run_ff;

  // the link clock stands still between frames, so cs low itself
  // clears the run flag; the next frame then starts counting from one
  always_ff @(posedge sclk_i or negedge cs_i)
  begin
    if (!cs_i)
      run_ff <= 1'b0;
    else
      run_ff <= 1'b1;
  end

  always_ff @(posedge sclk_i)
  begin
    if (cs_i)
      sh_ff <= {sh_ff[30:0], data_i};
  end

  // a cut frame leaves a wrong count, which the length check drops
  always_ff @(posedge sclk_i)
  begin
    if (cs_i)
      cnt_ff <= run_ff ? cnt_ff + 1'b1 : FRM_CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain synchronisers
  logic [2:0] cs_sync_ff;
  logic [2:0] io_sync_ff;
  logic cs_seen_ff;
  logic io_ok_ff;
  logic evt_ff;
  logic [31:0] word_ff;
  logic [FRM_CNT_W-1:0] len_ff;
  logic cs_fall;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cs_sync_ff <= '0;
    else
      cs_sync_ff <= {cs_sync_ff[1:0], cs_i};
  end

  always_ff @(posedge mclk_i)
  begin
    io_sync_ff <= {io_sync_ff[1:0], io_supply_ok_i};
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      io_ok_ff <= 1'b0;
    else if (io_sync_ff[2] == io_sync_ff[1])
      io_ok_ff <= io_sync_ff[1];
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      cs_seen_ff <= 1'b0;
    else if (cs_sync_ff[2] == cs_sync_ff[1])
      cs_seen_ff <= cs_sync_ff[1];
  end

  assign cs_fall = cs_seen_ff && !cs_sync_ff[2] && !cs_sync_ff[1];

  // shift word and count are still once cs is low and the link clock
  // stands, so they are read here without a handshake; limitation: the
  // host must not start the next frame within about four system cycles
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      word_ff <= '0;
      len_ff <= '0;
    end
    else if (cs_fall)
    begin
      word_ff <= sh_ff;
      len_ff <= cnt_ff;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      evt_ff <= 1'b0;
    else
      evt_ff <= cs_fall;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decode: length, header and id checks; writes only
  function automatic logic frame_ok(input logic [31:0] w, input logic [FRM_CNT_W-1:0] n);
    logic ok;
    ok = 1'b0;
    if (n == FRAME_LONG[FRM_CNT_W-1:0])
      ok = (w[31:30] == HDR_LONG) && !w[29] && (w[28:21] == DEV_ID);
    else if (n == FRAME_SHORT[FRM_CNT_W-1:0])
      ok = !w[29] && (w[28:21] == DEV_ID);
    return ok;
  endfunction

  logic frame_good;
  assign frame_good = evt_ff && frame_ok(word_ff, len_ff) && io_ok_ff;

  ////////////////////////////////////////////////////////////////////////////
  // power sequencing
  tbsc_mode_t mode_ff;
  logic [$clog2(STARTUP_CYCLES+1)-1:0] st_cnt_ff;
  logic pwr_cmd;
  assign pwr_cmd = frame_good && (word_ff[20:16] == ADDR_PWR);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !io_ok_ff || !analog_supply_ok_i)
    begin
      mode_ff <= TBSC_SHUTDOWN;
      st_cnt_ff <= '0;
    end
    else
    begin
      unique case (mode_ff)
        TBSC_SHUTDOWN:
        begin
          mode_ff <= TBSC_STARTUP;
          st_cnt_ff <= '0;
        end
        TBSC_STARTUP:
        begin
          st_cnt_ff <= st_cnt_ff + 1'b1;
          if (st_cnt_ff == $bits(st_cnt_ff)'(STARTUP_CYCLES - 1))
            mode_ff <= TBSC_ACTIVE;
        end
        TBSC_ACTIVE, TBSC_LOWPWR:
        begin
          if (pwr_cmd && word_ff[1:0] == PWR_STARTUP)
          begin
            mode_ff <= TBSC_STARTUP;
            st_cnt_ff <= '0;
          end
          else if (pwr_cmd && word_ff[1:0] == PWR_LOWPWR && mode_ff == TBSC_ACTIVE)
            mode_ff <= TBSC_LOWPWR;
          else if (pwr_cmd && word_ff[1:0] == PWR_ACTIVE)
            mode_ff <= TBSC_ACTIVE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command register and outputs
  logic in_reset;
  assign in_reset = rst_i || !io_ok_ff || mode_ff == TBSC_SHUTDOWN ||
                    (mode_ff == TBSC_STARTUP && st_cnt_ff == '0);

  always_ff @(posedge mclk_i)
  begin
    if (in_reset)
    begin
      boost_level_o <= BOOST_LEVEL_RST;
      cmd_o <= '0;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= frame_good && mode_ff != TBSC_STARTUP;
      if (frame_good && mode_ff != TBSC_STARTUP)
      begin
        cmd_o <= '{addr: word_ff[20:16], data: word_ff[15:0]};
        if (word_ff[20:16] == ADDR_BOOST)
          boost_level_o <= word_ff[3:0];
      end
    end
  end

  // outputs float in every mode but active, startup included
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      outputs_hiz_o <= 1'b1;
    else
      outputs_hiz_o <= mode_ff != TBSC_ACTIVE;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      active_o <= 1'b0;
    else
      active_o <= mode_ff == TBSC_ACTIVE;
  end

  // data pin is never driven: no read-back exists in 3-wire mode
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      data_o <= 1'b0;
      data_oe_o <= 1'b0;
    end
    else
    begin
      data_o <= 1'b0;
      data_oe_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost: hysteretic enable, spread-spectrum switching clock
  logic [2:0] cmp_sync_ff;
  logic boost_on_ff;
  logic [7:0] half_ff;
  logic [7:0] ph_ff;
  logic [7:0] lfsr_ff;
  logic boost_run;
  assign boost_run = mode_ff == TBSC_STARTUP || mode_ff == TBSC_ACTIVE;

  always_ff @(posedge mclk_i)
  begin
    cmp_sync_ff <= {cmp_sync_ff[1:0], boost_below_ref_i};
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !boost_run)
      boost_on_ff <= 1'b0;
    else if (cmp_sync_ff[2] == cmp_sync_ff[1])
      boost_on_ff <= cmp_sync_ff[1];
  end

  // half period picked from lfsr, band from BOOST_HALF_MIN up to BOOST_HALF_MAX, lying mostly above the average
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !boost_on_ff)
    begin
      ph_ff <= '0;
      half_ff <= 8'(BOOST_HALF_AVG);
      lfsr_ff <= 8'h01;
      boost_sw_o <= 1'b0;
    end
    else if (ph_ff + 1'b1 >= half_ff)
    begin
      ph_ff <= '0;
      boost_sw_o <= ~boost_sw_o;
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
      half_ff <= 8'(BOOST_HALF_MIN +
                  ((32'(lfsr_ff) * (BOOST_HALF_MAX - BOOST_HALF_MIN)) >> 8));
    end
    else
      ph_ff <= ph_ff + 1'b1;
  end
endmodule // tbsc_top
`default_nettype wire

// [verif/tbsc_checker.sv]
// Purpose: port checks for tbsc_top
// Assumes: one mclk domain, sync reset
// Notes: bind at the foot of the file
`timescale 1ns/1ps
`default_nettype none
module tbsc_checker (
  input wire logic mclk_i, // clock
  input wire logic rst_i, // reset
  input wire logic io_supply_ok_i, // io supply level
  input wire logic cs_i, // chip select
  input wire logic data_oe_o, // data pin enable
  input wire logic boost_sw_o, // boost gate
  input wire logic [3:0] boost_level_o, // boost code
  input wire logic outputs_hiz_o, // outputs hi-z
  input wire logic active_o, // active mode
  input wire logic cmd_valid_o, // command pulse
  input wire tbsc_pkg::tbsc_cmd_t cmd_o // last command
);
  import tbsc_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // eight samples cover the sync, mode update, output flop and boost stop
  sequence io_low;
    !io_supply_ok_i [*8];
  endsequence
  sequence in_frame;
    cs_i [*8];
  endsequence
  oe_never_a: assert property (!data_oe_o)
    else $error("data pin driven");
  hiz_mode_a: assert property (outputs_hiz_o == !active_o)
    else $error("hi-z does not follow mode");
  io_shutdown_a: assert property (io_low |-> !active_o && !boost_sw_o)
    else $error("no shutdown with io supply low");
  pulse_one_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse too wide");
  cmd_hold_a: assert property (io_supply_ok_i [*5] ##0 $changed(cmd_o) |-> cmd_valid_o)
    else $error("command changed without pulse");
  level_set_a: assert property (cmd_valid_o && cmd_o.addr == ADDR_BOOST
    |-> ##[0:1] boost_level_o == cmd_o.data[3:0])
    else $error("boost level not written");
  no_early_a: assert property (in_frame |-> !cmd_valid_o)
    else $error("command taken mid frame");
  rst_dflt_a: assert property ($fell(rst_i) |-> boost_level_o == BOOST_LEVEL_RST && outputs_hiz_o)
    else $error("reset defaults wrong");
endmodule // tbsc_checker
bind tbsc_top tbsc_checker u_chk (.mclk_i, .rst_i, .io_supply_ok_i, .cs_i, .data_oe_o,
  .boost_sw_o, .boost_level_o, .outputs_hiz_o, .active_o, .cmd_valid_o, .cmd_o);
`default_nettype wire

// [verif/tbsc_host.sv]
// Purpose: serial host model
// Assumes: 30 ns link clock
// Notes: clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module tbsc_host (
  output var logic sclk_o, // serial clock
  output var logic cs_o, // chip select
  output var logic data_o // serial data
);
  initial
  begin
    sclk_o = 1'b0;
    cs_o = 1'b0;
    data_o = 1'b0;
  end
  // cut above zero drops chip select early
  task automatic send(input int n, input logic [39:0] w, input int cut);
    cs_o = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      data_o = w[i];
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
      if (cut == n - i)
        break;
    end
    #10 cs_o = 1'b0;
    // idle data flips so a stale level is never read as valid
    data_o = ~data_o;
  endtask
endmodule // tbsc_host
`default_nettype wire

// [verif/tbsc_top_test.sv]
// Purpose: bench for tbsc_top
// Assumes: short startup count in sim
// Notes: bench inputs change on falling mclk, host serial lines on their own 30 ns timing
`timescale 1ns/1ps
`default_nettype none
module tbsc_top_test;
  import tbsc_pkg::*;
  localparam int unsigned SU = 50;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic io_supply_ok_i = 1'b0;
  logic boost_below_ref_i = 1'b0;
  logic sclk_i, cs_i, data_i, data_o, data_oe_o, boost_sw_o, outputs_hiz_o, active_o, cmd_valid_o;
  logic [3:0] boost_level_o;
  tbsc_cmd_t cmd_o;
  int fail_count = 0;
  int checks_done = 0;
  tbsc_host u_host (.sclk_o(sclk_i), .cs_o(cs_i), .data_o(data_i));
  tbsc_top #(.STARTUP_CYCLES(SU)) u_dut (.mclk_i, .rst_i, .analog_supply_ok_i(1'b1),
    .io_supply_ok_i, .sclk_i, .cs_i, .data_i, .boost_below_ref_i, .data_o, .data_oe_o,
    .boost_sw_o, .boost_level_o, .outputs_hiz_o, .active_o, .cmd_valid_o, .cmd_o);
  initial
  begin
    forever #4 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  function automatic logic [39:0] wd(input logic [4:0] a, input logic [15:0] d);
    return {8'h00, 2'b11, 1'b0, DEV_ID, a, d};
  endfunction
  // twelve cycles cover the sync latency and the gap between frames
  task automatic frame(input int n, input logic [39:0] w, input int cut, input logic ok);
    logic seen;
    u_host.send(n, w, cut);
    seen = 1'b0;
    repeat (12)
    begin
      @(negedge mclk_i);
      if (cmd_valid_o === 1'b1)
        seen = 1'b1;
    end
    chk(seen, ok);
  endtask
  task automatic wait_active();
    int k;
    for (k = 0; k < 80 && active_o !== 1'b1; k++)
      @(negedge mclk_i);
    chk(k >= SU && k <= SU + 8, 1'b1);
    chk({outputs_hiz_o, boost_level_o, data_oe_o, data_o}, 7'h3c);
  endtask
  ////////////////////////////////////////
  task automatic t_power();
    cyc(6);
    rst_i = 1'b0;
    cyc(20);
    chk({active_o, outputs_hiz_o}, 2'b01);
    // also primes the unreset link flops before any real frame
    frame(32, wd(ADDR_BOOST, 16'h0003), 0, 1'b0);
    io_supply_ok_i = 1'b1;
    wait_active();
  endtask
  task automatic t_frames();
    frame(32, wd(ADDR_BOOST, 16'h0005), 0, 1'b1);
    chk({cmd_o, boost_level_o}, {ADDR_BOOST, 16'h0005, 4'h5});
    frame(30, wd(ADDR_BOOST, 16'h0009), 0, 1'b1);
    chk(boost_level_o, 4'h9);
    frame(31, wd(ADDR_BOOST, 16'h0003), 0, 1'b0);
    frame(33, wd(ADDR_BOOST, 16'h0003), 0, 1'b0);
    frame(32, wd(ADDR_BOOST, 16'h0003), 20, 1'b0);
    frame(32, wd(ADDR_BOOST, 16'h0003) ^ 40'h20000000, 0, 1'b0);
    frame(32, wd(ADDR_BOOST, 16'h0003) ^ 40'h40000000, 0, 1'b0);
    chk(boost_level_o, 4'h9);
  endtask
  task automatic t_mode();
    frame(32, wd(ADDR_PWR, {14'h0, PWR_LOWPWR}), 0, 1'b1);
    cyc(4);
    chk({active_o, outputs_hiz_o}, 2'b01);
    frame(30, wd(ADDR_PWR, {14'h0, PWR_ACTIVE}), 0, 1'b1);
    cyc(4);
    chk({active_o, outputs_hiz_o}, 2'b10);
  endtask
  task automatic t_boost();
    int n;
    logic last;
    boost_below_ref_i = 1'b1;
    cyc(10);
    n = 0;
    last = boost_sw_o;
    repeat (400)
    begin
      @(negedge mclk_i);
      n += (boost_sw_o !== last);
      last = boost_sw_o;
    end
    chk(n >= 4 && n <= 22, 1'b1);
    boost_below_ref_i = 1'b0;
    cyc(120);
    chk(boost_sw_o, 1'b0);
  endtask
  task automatic t_io_off();
    io_supply_ok_i = 1'b0;
    cyc(8);
    chk({active_o, outputs_hiz_o, boost_level_o}, 6'h1f);
    io_supply_ok_i = 1'b1;
    wait_active();
  endtask
  ////////////////////////////////////////
  initial
  begin
    t_power();
    t_frames();
    t_mode();
    t_boost();
    t_io_off();
    close_out();
  end
  initial
  begin
    #100000;
    fail_count++;
    close_out();
  end
endmodule // tbsc_top_test
`default_nettype wire
